// file: rtl/rscb_pkg.sv
// Purpose: shared constants for the ring status, claim and beacon engine
// Assumes: one ring clock, symbols arrive and leave as pairs, one pair a clock
// Notes: register offsets are byte addresses on a 32-bit AHB-Lite bus
package rscb_pkg;
	localparam logic [2:0] SYM_DATA = 3'h0;
	localparam logic [2:0] SYM_R = 3'h1;
	localparam logic [2:0] SYM_S = 3'h2;
	localparam logic [2:0] SYM_T = 3'h3;
	localparam logic [2:0] SYM_I = 3'h4;
	localparam logic [2:0] SYM_OTHER = 3'h5;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FUNC = 8'h04;
	localparam logic [7:0] OFS_TREQ = 8'h08;
	localparam logic [7:0] OFS_TBT = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	localparam int CTRL_EXT_IND = 0;
	localparam int CTRL_INH_RECOV = 1;
	localparam int CTRL_INH_TOKEN = 2;
	localparam int FUNC_CLAIM = 0;
	localparam int FUNC_BEACON = 1;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [31:0] TBT_RESET = 32'h0000_0000;

	localparam logic [1:0] KIND_CLAIM = 2'h0;
	localparam logic [1:0] KIND_BEACON = 2'h1;
	localparam logic [1:0] KIND_OTHER = 2'h2;
	localparam logic [1:0] CLS_MY = 2'h0;
	localparam logic [1:0] CLS_HIGHER = 2'h1;
	localparam logic [1:0] CLS_LOWER = 2'h2;
	localparam logic [1:0] CLS_OTHER = 2'h3;

	localparam logic [7:0] FC_CLAIM = 8'hc3;
	localparam logic [7:0] FC_BEACON = 8'hc2;
	localparam int INFO_BYTES = 4;

	// target rotation request: 20.48 us steps, at most 1.34 s
	localparam int TREQ_STEP_NS = 20480;
	localparam int TREQ_MAX_MS = 1340;
	// worked out in 64 bits, though the product, 1340000000, would also fit an int
	localparam int TREQ_MAX_STEPS = int'((longint'(TREQ_MAX_MS) * 1000000) / TREQ_STEP_NS);
	localparam int TREQ_W = $clog2(TREQ_MAX_STEPS + 1);
	localparam logic [TREQ_W-1:0] TREQ_RESET = '0;
endpackage

// file: rtl/rscb_gen.sv
// Purpose: serialises an internally generated claim or beacon frame body
// Assumes: ready comes from the transmit path on the same clock
// Notes: frame is one FC byte then the information field, most significant first
`timescale 1ns/1ns
module rscb_gen
	import rscb_pkg::*;
#(
	parameter int NBYTES = INFO_BYTES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic ready,
	input wire logic [7:0] fc,
	input wire logic [8*NBYTES-1:0] info,
	output logic [7:0] byte_o,
	output logic valid_o,
	output logic last_o,
	output logic sent_one_o
);
	if (NBYTES < 1 || NBYTES > 8) begin : g_bad_nbytes
		$error("rscb_gen: NBYTES out of range");
	end

	localparam int IW = $clog2(NBYTES + 1);
	logic [IW-1:0] idx_r, idx_nxt;
	logic [7:0] byte_r, byte_nxt;
	logic valid_r, valid_nxt, last_r, last_nxt, sent_r, sent_nxt;

	always_comb begin
		idx_nxt = idx_r;
		byte_nxt = byte_r;
		valid_nxt = valid_r;
		last_nxt = last_r;
		// one pulse for every frame whose last byte is taken, also while pausing
		sent_nxt = valid_r && last_r && ready;
		if (!run) begin
			if (!valid_r || ready) begin
				valid_nxt = 1'b0;
				last_nxt = 1'b0;
				idx_nxt = '0;
			end
		end else if (!valid_r || ready) begin
			valid_nxt = 1'b1;
			if (idx_r == '0)
				byte_nxt = fc;
			else
				byte_nxt = info[8*(NBYTES-int'(idx_r)) +: 8];
			last_nxt = (idx_r == IW'(NBYTES));
			idx_nxt = (idx_r == IW'(NBYTES)) ? '0 : idx_r + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_r <= '0;
			byte_r <= 8'h00;
			valid_r <= 1'b0;
			last_r <= 1'b0;
			sent_r <= 1'b0;
		end else begin
			idx_r <= idx_nxt;
			byte_r <= byte_nxt;
			valid_r <= valid_nxt;
			last_r <= last_nxt;
			sent_r <= sent_nxt;
		end
	end

	assign byte_o = byte_r;
	assign valid_o = valid_r;
	assign last_o = last_r;
	assign sent_one_o = sent_r;
endmodule

// file: rtl/rscb_ring.sv
// Purpose: frame status rewrite, claim and beacon recovery engine with AHB-Lite registers
// Assumes: symbol pairs, frame parser flags and timer events all on hclk
// Notes: hreadyout is always high, every access finishes in its first data cycle
// Function
// - first T arriving off boundary is sent as the sequence T S I I
// - error flag: local FCS failed or received E not R
// - address flag from internal match, or external input when option set
// - copy flag is copy_valid_in delayed one clock
// - external C input sampled one byte before the ending delimiter
// - next-station flag sampled together with the received A indicator
// - on next-station frames only the station setting A may set C
// - valid MAC frame clears ring operational unless it is an own claim that wins, picks state
// - claim classified My, Higher, Lower or Other by source match and bid
// - each received claim reported as claim with its subtype
// - claim frames sent continuously; host claim only after one internal
// - internal claim info field is the four-byte requested rotation time
// - requested rotation time in 20.48 us steps up to 1.34 s
// - recovery on late TRT expiry, TVX expiry, Lower claim or My beacon
// - inhibit option blocks recovery; force claim command always enters claim
// - higher claim in claim state goes to idle and repeats
// - lower claim in claim state keeps sending own claims
// - own claim returned wins; token issued and ring made operational
// - inhibit token release keeps a winner in claim state
// - beacon is My when source matches station address, else Other
// - beacon frames sent continuously; host beacon only after one internal
// - internal beacon info field carries the beacon type value
`timescale 1ns/1ns
module rscb_ring
	import rscb_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [2:0] rx_sym_a,
	input wire logic [2:0] rx_sym_b,
	output logic [2:0] tx_sym_a,
	output logic [2:0] tx_sym_b,
	input wire logic fcs_bad_in,
	input wire logic int_addr_recognized_in,
	input wire logic ext_addr_recognized_in,
	input wire logic copy_valid_in,
	input wire logic ext_c_in,
	input wire logic nsa_frame_in,
	input wire logic mac_frame_valid_in,
	input wire logic [1:0] mac_frame_kind_in,
	input wire logic sa_match_in,
	input wire logic [31:0] bid_in,
	input wire logic trt_expired_in,
	input wire logic late_flag_in,
	input wire logic tvx_expired_in,
	input wire logic imm_req_in,
	input wire logic imm_done_in,
	input wire logic tx_ready_in,
	output logic [7:0] gen_byte,
	output logic gen_valid,
	output logic gen_last,
	output logic imm_grant,
	output logic token_issue,
	output logic ring_operational,
	output logic rx_report_valid,
	output logic [1:0] rx_report_kind,
	output logic [1:0] rx_report_class
);
	typedef enum logic [1:0] {ST_IDLE, ST_CLAIM, ST_BEACON, ST_DATA} rscb_state_t;
	typedef enum logic [1:0] {IND_BODY, IND_AC, IND_FILL} rscb_ind_t;

	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt, tbt_r, tbt_nxt;
	logic [2:0] ctrl_r, ctrl_nxt;
	logic [TREQ_W-1:0] treq_r, treq_nxt;
	logic force_claim_cmd, force_claim_nxt, force_beacon_r, force_beacon_nxt, addr_phase;
	logic [7:0] a_ofs;
	rscb_state_t st_r, st_nxt;
	logic [1:0] last_class_r, last_class_nxt;
	logic ring_op_r, ring_op_nxt, imm_act_r, imm_act_nxt, token_r, token_nxt, sent_ok_r, sent_ok_nxt;

	assign addr_phase = hsel && hready && htrans[1];
	assign a_ofs = haddr[7:0];

	always_comb begin
		wr_pend_nxt = addr_phase && hwrite;
		wr_addr_nxt = a_ofs;
		hrdata_nxt = 32'h0000_0000;
		ctrl_nxt = ctrl_r;
		treq_nxt = treq_r;
		tbt_nxt = tbt_r;
		force_claim_nxt = 1'b0;
		force_beacon_nxt = 1'b0;
		if (addr_phase && !hwrite) begin
			case (a_ofs)
				OFS_CTRL: hrdata_nxt = {29'h0, ctrl_r};
				OFS_TREQ: hrdata_nxt = 32'(treq_r);
				OFS_TBT: hrdata_nxt = tbt_r;
				OFS_STATUS: hrdata_nxt = {25'h0, imm_act_r, last_class_r, ring_op_r, 1'b0, st_r};
				default: hrdata_nxt = 32'h0000_0000;
			endcase
		end
		if (wr_pend_r) begin
			case (wr_addr_r)
				OFS_CTRL: ctrl_nxt = hwdata[2:0];
				OFS_FUNC: begin
					force_claim_nxt = hwdata[FUNC_CLAIM];
					force_beacon_nxt = hwdata[FUNC_BEACON];
				end
				OFS_TREQ: treq_nxt = hwdata[TREQ_W-1:0];
				OFS_TBT: tbt_nxt = hwdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			ctrl_r <= CTRL_RESET;
			treq_r <= TREQ_RESET;
			tbt_r <= TBT_RESET;
			force_claim_cmd <= 1'b0;
			force_beacon_r <= 1'b0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata_r <= hrdata_nxt;
			ctrl_r <= ctrl_nxt;
			treq_r <= treq_nxt;
			tbt_r <= tbt_nxt;
			force_claim_cmd <= force_claim_nxt;
			force_beacon_r <= force_beacon_nxt;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	logic ext_ind_option, inhibit_recovery_option, inhibit_token_option;
	assign ext_ind_option = ctrl_r[CTRL_EXT_IND];
	assign inhibit_recovery_option = ctrl_r[CTRL_INH_RECOV];
	assign inhibit_token_option = ctrl_r[CTRL_INH_TOKEN];

	rscb_ind_t ind_r, ind_nxt;
	logic prev_data_r, prev_data_nxt, copy_d_r, copy_d_nxt, ext_c_r, ext_c_nxt;
	logic eflag_r, eflag_nxt, aflag_r, aflag_nxt, copy_r, copy_nxt;
	logic [2:0] txa_r, txa_nxt, txb_r, txb_nxt;
	logic aflag_now, nsa_now, c_set;

	assign aflag_now = ext_ind_option ? ext_addr_recognized_in : int_addr_recognized_in;

	always_comb begin
		ind_nxt = ind_r;
		eflag_nxt = eflag_r;
		aflag_nxt = aflag_r;
		copy_nxt = copy_r;
		txa_nxt = rx_sym_a;
		txb_nxt = rx_sym_b;
		copy_d_nxt = copy_valid_in;
		ext_c_nxt = ext_c_in;
		prev_data_nxt = (rx_sym_a == SYM_DATA) && (rx_sym_b == SYM_DATA);
		nsa_now = nsa_frame_in;
		c_set = 1'b0;
		case (ind_r)
			IND_BODY: begin
				if (prev_data_r && rx_sym_a == SYM_T) begin
					// aligned ending delimiter, E rides in the second half
					eflag_nxt = fcs_bad_in || (rx_sym_b != SYM_R);
					aflag_nxt = aflag_now;
					copy_nxt = copy_d_r || ext_c_r;
					txb_nxt = (fcs_bad_in || rx_sym_b != SYM_R) ? SYM_S : SYM_R;
					ind_nxt = IND_AC;
				end else if (prev_data_r && rx_sym_a == SYM_DATA && rx_sym_b == SYM_T) begin
					txa_nxt = SYM_T;
					txb_nxt = SYM_S;
					ind_nxt = IND_FILL;
				end
			end
			IND_AC: begin
				ind_nxt = IND_BODY;
				if (!eflag_r) begin
					if (rx_sym_a == SYM_R) begin
						txa_nxt = aflag_r ? SYM_S : SYM_R;
						if (aflag_r)
							txb_nxt = copy_r ? SYM_S : SYM_R;
					end else if (rx_sym_a == SYM_S && aflag_r) begin
						// someone else set A on a next-station frame: leave C alone
						c_set = copy_r && !nsa_now;
						txb_nxt = (c_set || rx_sym_b == SYM_S) ? SYM_S : SYM_R;
					end
				end
			end
			IND_FILL: begin
				txa_nxt = SYM_I;
				txb_nxt = SYM_I;
				ind_nxt = IND_BODY;
			end
			default: ind_nxt = IND_BODY;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ind_r <= IND_BODY;
			prev_data_r <= 1'b0;
			copy_d_r <= 1'b0;
			ext_c_r <= 1'b0;
			eflag_r <= 1'b0;
			aflag_r <= 1'b0;
			copy_r <= 1'b0;
			txa_r <= SYM_I;
			txb_r <= SYM_I;
		end else begin
			ind_r <= ind_nxt;
			prev_data_r <= prev_data_nxt;
			copy_d_r <= copy_d_nxt;
			ext_c_r <= ext_c_nxt;
			eflag_r <= eflag_nxt;
			aflag_r <= aflag_nxt;
			copy_r <= copy_nxt;
			txa_r <= txa_nxt;
			txb_r <= txb_nxt;
		end
	end

	assign tx_sym_a = txa_r;
	assign tx_sym_b = txb_r;

	logic [31:0] treq_bid;
	logic is_claim, is_beacon, is_other, my_claim, higher_claim, lower_claim, my_beacon, other_beacon;
	logic recovery, gen_run, gen_sent, frame_out, rep_valid_r, rep_valid_nxt;
	logic [1:0] rep_kind_r, rep_kind_nxt, cls;

	assign treq_bid = 32'(treq_r);
	assign is_claim = mac_frame_valid_in && mac_frame_kind_in == KIND_CLAIM;
	assign is_beacon = mac_frame_valid_in && mac_frame_kind_in == KIND_BEACON;
	assign is_other = mac_frame_valid_in && mac_frame_kind_in == KIND_OTHER;
	assign my_claim = is_claim && sa_match_in && bid_in == treq_bid;
	assign higher_claim = is_claim && !sa_match_in && bid_in > treq_bid;
	assign lower_claim = is_claim && !sa_match_in && bid_in < treq_bid;
	assign my_beacon = is_beacon && sa_match_in;
	assign other_beacon = is_beacon && !sa_match_in;
	assign recovery = ((trt_expired_in && late_flag_in) || tvx_expired_in || lower_claim || my_beacon)
		&& !inhibit_recovery_option;

	always_comb begin
		if (is_claim)
			cls = my_claim ? CLS_MY : (higher_claim ? CLS_HIGHER : (lower_claim ? CLS_LOWER : CLS_OTHER));
		else if (is_beacon)
			cls = my_beacon ? CLS_MY : CLS_OTHER;
		else
			cls = CLS_OTHER;
	end

	always_comb begin
		st_nxt = st_r;
		ring_op_nxt = ring_op_r;
		token_nxt = 1'b0;
		rep_valid_nxt = mac_frame_valid_in;
		rep_kind_nxt = mac_frame_valid_in ? mac_frame_kind_in : rep_kind_r;
		last_class_nxt = mac_frame_valid_in ? cls : last_class_r;
		if (mac_frame_valid_in)
			ring_op_nxt = 1'b0;
		case (st_r)
			ST_CLAIM: begin
				if (higher_claim || is_other || other_beacon)
					st_nxt = ST_IDLE;
				else if (my_claim && !inhibit_token_option) begin
					st_nxt = ST_DATA;
					ring_op_nxt = 1'b1;
					token_nxt = 1'b1;
				end else if (trt_expired_in)
					st_nxt = ST_BEACON;
				// lower or own claim under inhibit: keep claiming
			end
			ST_BEACON: begin
				if (other_beacon)
					st_nxt = ST_IDLE;
				else if (my_beacon)
					st_nxt = ST_CLAIM;
			end
			default: begin
				if (is_beacon)
					st_nxt = ST_IDLE;
				if (recovery)
					st_nxt = ST_CLAIM;
			end
		endcase
		if (force_beacon_r)
			st_nxt = ST_BEACON;
		if (force_claim_cmd) begin
			st_nxt = ST_CLAIM;
			ring_op_nxt = 1'b0;
		end
	end

	// host frames wait for one internal frame, then take over at a frame boundary
	assign frame_out = sent_ok_r || gen_sent;
	always_comb begin
		imm_act_nxt = imm_act_r;
		// any change of state asks for a fresh internal frame
		sent_ok_nxt = frame_out && (st_nxt == st_r);
		if (st_r != ST_CLAIM && st_r != ST_BEACON)
			imm_act_nxt = 1'b0;
		else if (imm_act_r && imm_done_in)
			imm_act_nxt = 1'b0;
		else if (!imm_act_r && imm_req_in && frame_out && !gen_valid)
			imm_act_nxt = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= ST_IDLE;
			ring_op_r <= 1'b0;
			token_r <= 1'b0;
			rep_valid_r <= 1'b0;
			rep_kind_r <= KIND_CLAIM;
			last_class_r <= CLS_OTHER;
			imm_act_r <= 1'b0;
			sent_ok_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ring_op_r <= ring_op_nxt;
			token_r <= token_nxt;
			rep_valid_r <= rep_valid_nxt;
			rep_kind_r <= rep_kind_nxt;
			last_class_r <= last_class_nxt;
			imm_act_r <= imm_act_nxt;
			sent_ok_r <= sent_ok_nxt;
		end
	end

	// generator pauses at a frame boundary once a host frame is pending
	assign gen_run = (st_r == ST_CLAIM || st_r == ST_BEACON) && !imm_act_r
		&& !(imm_req_in && (gen_valid ? gen_last : frame_out));

	rscb_gen #(
		.NBYTES(INFO_BYTES)
	) u_gen (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(gen_run),
		.ready(tx_ready_in),
		.fc(st_r == ST_BEACON ? FC_BEACON : FC_CLAIM),
		.info(st_r == ST_BEACON ? tbt_r : treq_bid),
		.byte_o(gen_byte),
		.valid_o(gen_valid),
		.last_o(gen_last),
		.sent_one_o(gen_sent)
	);

	assign imm_grant = imm_act_r;
	assign token_issue = token_r;
	assign ring_operational = ring_op_r;
	assign rx_report_valid = rep_valid_r;
	assign rx_report_kind = rep_kind_r;
	assign rx_report_class = last_class_r;
endmodule

// file: verification/rscb_ring_chk.sv
// Purpose: port-level checks on the ring status, claim and beacon engine
// Assumes: single hclk domain, hresetn active low
// Notes: bound onto the engine from the bench top
`timescale 1ns/1ns
module rscb_ring_chk
	import rscb_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [2:0] rx_sym_a,
	input wire logic [2:0] rx_sym_b,
	input wire logic [2:0] tx_sym_a,
	input wire logic [2:0] tx_sym_b,
	input wire logic fcs_bad_in,
	input wire logic mac_frame_valid_in,
	input wire logic [1:0] mac_frame_kind_in,
	input wire logic sa_match_in,
	input wire logic tx_ready_in,
	input wire logic imm_done_in,
	input wire logic [7:0] gen_byte,
	input wire logic gen_valid,
	input wire logic imm_grant,
	input wire logic token_issue,
	input wire logic ring_operational,
	input wire logic rx_report_valid,
	input wire logic [1:0] rx_report_kind,
	input wire logic [1:0] rx_report_class
);
	default clocking dcb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus stalled or errored");
	chk_odd_end: assert property (rx_sym_a == SYM_DATA && rx_sym_b == SYM_T |=>
		tx_sym_a == SYM_T && tx_sym_b == SYM_S ##1 tx_sym_a == SYM_I && tx_sym_b == SYM_I)
		else $error("off boundary end not sent as T S I I");
	chk_e_set: assert property ($past(rx_sym_a) == SYM_DATA && $past(rx_sym_b) == SYM_DATA &&
		rx_sym_a == SYM_T && (fcs_bad_in || rx_sym_b != SYM_R) |=> tx_sym_b == SYM_S)
		else $error("error indicator not set");
	chk_report_lat: assert property (rx_report_valid == $past(mac_frame_valid_in))
		else $error("report strobe late or spurious");
	chk_claim_kind: assert property (mac_frame_valid_in && mac_frame_kind_in == KIND_CLAIM |=>
		rx_report_kind == KIND_CLAIM && rx_report_class != CLS_OTHER)
		else $error("claim report wrong");
	chk_beacon_cls: assert property (mac_frame_valid_in && mac_frame_kind_in == KIND_BEACON |=>
		rx_report_kind == KIND_BEACON && rx_report_class == ($past(sa_match_in) ? CLS_MY : CLS_OTHER))
		else $error("beacon class wrong");
	chk_rop_clear: assert property (mac_frame_valid_in &&
		!(mac_frame_kind_in == KIND_CLAIM && sa_match_in) |=> !ring_operational)
		else $error("ring operational kept after MAC frame");
	chk_token_win: assert property (token_issue |-> ring_operational ##1 !token_issue)
		else $error("token pulse without operational ring");
	chk_gen_hold: assert property (gen_valid && !tx_ready_in |=> $stable(gen_byte) || !gen_valid)
		else $error("frame byte changed while stalled");
	chk_grant_gap: assert property ($rose(imm_grant) |-> !$past(gen_valid))
		else $error("grant during internal frame");
	chk_grant_drop: assert property (imm_grant && imm_done_in |=> !imm_grant)
		else $error("grant held after done");
endmodule

// file: verification/rscb_phy.sv
// Purpose: ring side stand-in feeding symbol pairs and pacing the transmit path
// Assumes: one symbol pair a clock on hclk
// Notes: the line idles with I pairs between frames
`timescale 1ns/1ns
module rscb_phy
	import rscb_pkg::*;
(
	input wire logic hclk,
	output logic [2:0] rx_sym_a,
	output logic [2:0] rx_sym_b,
	output logic tx_ready_in
);
	integer seed = 32'hf655;
	initial begin
		rx_sym_a = SYM_I;
		rx_sym_b = SYM_I;
		tx_ready_in = 1'b0;
	end
	task automatic put(input logic [2:0] a, input logic [2:0] b);
		@(posedge hclk);
		rx_sym_a <= a;
		rx_sym_b <= b;
	endtask
	// accepts about two cycles in three, so bytes wait now and then
	always @(posedge hclk) begin
		tx_ready_in <= ($random(seed) % 3) != 0;
	end
endmodule

// file: verification/tb_rscb_ring.sv
// Purpose: self-checking bench for the ring status, claim and beacon engine
// Assumes: hreadyout always high, one symbol pair a clock
// Notes: random status and claim cases from a fixed seed plus directed recovery steps
`timescale 1ns/1ns
module tb_rscb_ring
	import rscb_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fcs_bad_in = 0, copy_valid_in = 0, ext_c_in = 0;
	logic int_addr_recognized_in = 0, ext_addr_recognized_in = 0, nsa_frame_in = 0, sa_match_in = 0;
	logic mac_frame_valid_in = 0, trt_expired_in = 0, late_flag_in = 0, tvx_expired_in = 0;
	logic imm_req_in = 0, imm_done_in = 0;
	logic [31:0] haddr = 0, hwdata = 0, bid_in = 0, hrdata, rd;
	logic [1:0] htrans = 0, mac_frame_kind_in = 0, rx_report_kind, rx_report_class;
	logic hreadyout, hresp, tx_ready_in, gen_valid, gen_last, imm_grant, token_issue, ring_operational;
	logic rx_report_valid;
	logic [2:0] rx_sym_a, rx_sym_b, tx_sym_a, tx_sym_b;
	logic [7:0] gen_byte;
	logic [7:0] ra[6] = '{OFS_CTRL, OFS_FUNC, OFS_TREQ, OFS_TBT, OFS_STATUS, 8'h20};
	logic [31:0] rv[6] = '{32'(CTRL_RESET), 32'h0, 32'(TREQ_RESET), TBT_RESET, 32'h30, 32'h0};
	integer seed = 32'hf655, err_count = 0, samples_checked = 0, cyc = 0, i;
	always #5 hclk = ~hclk;
	rscb_ring u_rscb_ring (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_sym_a, .rx_sym_b, .tx_sym_a, .tx_sym_b,
		.fcs_bad_in, .int_addr_recognized_in, .ext_addr_recognized_in, .copy_valid_in, .ext_c_in,
		.nsa_frame_in, .mac_frame_valid_in, .mac_frame_kind_in, .sa_match_in, .bid_in, .trt_expired_in,
		.late_flag_in, .tvx_expired_in, .imm_req_in, .imm_done_in, .tx_ready_in, .gen_byte, .gen_valid,
		.gen_last, .imm_grant, .token_issue, .ring_operational, .rx_report_valid, .rx_report_kind,
		.rx_report_class);
	rscb_phy u_rscb_phy (.hclk, .rx_sym_a, .rx_sym_b, .tx_ready_in);
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_sym(input logic [5:0] g, input logic [5:0] e);
		cmp_val(32'(g), 32'(e));
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= 32'(a);
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic st(input logic [1:0] s, input logic rop);
		repeat (3) @(posedge hclk);
		bus(0, OFS_STATUS, 0);
		cmp_val(32'({rd[3], rd[1:0]}), 32'({rop, s}));
	endtask
	task automatic timer(input logic t, input logic late);
		@(posedge hclk);
		trt_expired_in <= t;
		tvx_expired_in <= !t;
		late_flag_in <= late;
		@(posedge hclk);
		trt_expired_in <= 0;
		tvx_expired_in <= 0;
	endtask
	task automatic mac(input logic [1:0] k, input logic s, input logic [31:0] b, input logic [1:0] cls);
		@(posedge hclk);
		mac_frame_valid_in <= 1;
		mac_frame_kind_in <= k;
		sa_match_in <= s;
		bid_in <= b;
		@(posedge hclk);
		mac_frame_valid_in <= 0;
		#1 cmp_val(32'({rx_report_valid, rx_report_kind, rx_report_class}), 32'({1'b1, k, cls}));
	endtask
	task automatic genchk(input logic [7:0] fc, input logic [31:0] info);
		logic [39:0] got;
		int n;
		n = 0;
		got = '0;
		while (n < 5) begin
			@(posedge hclk);
			if (gen_valid && tx_ready_in) begin
				got = {got[31:0], gen_byte};
				cmp_val(32'({imm_grant, gen_last}), 32'({1'b0, n == 4}));
				n++;
			end
		end
		cmp_val(got[31:0], info);
		cmp_val(32'(got[39:32]), 32'(fc));
	endtask
	// one aligned frame end: E A C after a data pair, side flags valid only at their moment
	task automatic frame;
		logic [31:0] r;
		logic [2:0] e, a, c, ao, co;
		logic ef, af, cf;
		r = $random(seed);
		e = r[0] ? SYM_S : SYM_R;
		a = r[1] ? SYM_S : SYM_R;
		c = r[2] ? SYM_S : SYM_R;
		ef = (r[3] & r[10]) | r[0];
		af = r[9] ? r[5] : r[4];
		cf = r[6] | r[7];
		ao = a;
		co = c;
		if (!ef && !r[1] && af) begin
			ao = SYM_S;
			co = cf ? SYM_S : SYM_R;
		end
		if (!ef && r[1] && af) co = ((cf && !r[8]) || r[2]) ? SYM_S : SYM_R;
		bus(1, OFS_CTRL, {29'h0, 2'b01, r[9]});
		u_rscb_phy.put(SYM_DATA, SYM_DATA);
		copy_valid_in <= r[6];
		ext_c_in <= r[7];
		u_rscb_phy.put(SYM_T, e);
		copy_valid_in <= !r[6];
		ext_c_in <= 0;
		fcs_bad_in <= r[3] & r[10];
		int_addr_recognized_in <= r[4];
		ext_addr_recognized_in <= r[5];
		u_rscb_phy.put(a, c);
		fcs_bad_in <= 0;
		int_addr_recognized_in <= !r[4];
		ext_addr_recognized_in <= !r[5];
		nsa_frame_in <= r[8];
		#1 cmp_sym({tx_sym_a, tx_sym_b}, {SYM_T, ef ? SYM_S : SYM_R});
		u_rscb_phy.put(SYM_I, SYM_I);
		nsa_frame_in <= !r[8];
		#1 cmp_sym({tx_sym_a, tx_sym_b}, {ao, co});
	endtask
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1;
		foreach (ra[j]) begin
			bus(0, ra[j], 0);
			cmp_val(rd, rv[j]);
		end
		bus(1, 8'h20, 32'hffff_ffff);
		bus(0, 8'h20, 0);
		cmp_val(rd, 0);
		bus(1, OFS_TREQ, 32'(TREQ_MAX_STEPS));
		bus(0, OFS_TREQ, 0);
		cmp_val(rd, 32'(TREQ_MAX_STEPS));
		u_rscb_phy.put(SYM_DATA, SYM_DATA);
		u_rscb_phy.put(SYM_DATA, SYM_T);
		u_rscb_phy.put(SYM_R, SYM_R);
		#1 cmp_sym({tx_sym_a, tx_sym_b}, {SYM_T, SYM_S});
		u_rscb_phy.put(SYM_S, SYM_R);
		#1 cmp_sym({tx_sym_a, tx_sym_b}, {SYM_I, SYM_I});
		u_rscb_phy.put(SYM_I, SYM_I);
		bus(1, OFS_TREQ, 32'h100);
		bus(1, OFS_TBT, 32'h5a3c_96e1);
		bus(1, OFS_CTRL, 32'h2);
		timer(0, 0);
		st(2'h0, 0);
		imm_req_in <= 1;
		bus(1, OFS_FUNC, 32'h1);
		genchk(FC_CLAIM, 32'h100);
		for (i = 0; i < 20 && imm_grant !== 1'b1; i++) @(posedge hclk);
		cmp_val(32'(imm_grant), 1);
		imm_done_in <= 1;
		@(posedge hclk);
		imm_done_in <= 0;
		imm_req_in <= 0;
		st(2'h1, 0);
		mac(KIND_CLAIM, 0, 32'hff, CLS_LOWER);
		st(2'h1, 0);
		mac(KIND_CLAIM, 0, 32'h101, CLS_HIGHER);
		st(2'h0, 0);
		bus(1, OFS_CTRL, 32'h0);
		timer(0, 0);
		st(2'h1, 0);
		timer(1, 0);
		st(2'h2, 0);
		mac(KIND_BEACON, 1, 0, CLS_MY);
		st(2'h1, 0);
		bus(1, OFS_CTRL, 32'h4);
		mac(KIND_CLAIM, 1, 32'h100, CLS_MY);
		st(2'h1, 0);
		bus(1, OFS_CTRL, 32'h0);
		mac(KIND_CLAIM, 1, 32'h100, CLS_MY);
		st(2'h3, 1);
		mac(KIND_OTHER, 0, 0, CLS_OTHER);
		repeat (3) @(posedge hclk);
		bus(0, OFS_STATUS, 0);
		cmp_val(32'(rd[3]), 0);
		timer(1, 1);
		st(2'h1, 0);
		mac(KIND_BEACON, 0, 0, CLS_OTHER);
		st(2'h0, 0);
		bus(1, OFS_FUNC, 32'h2);
		genchk(FC_BEACON, 32'h5a3c_96e1);
		st(2'h2, 0);
		mac(KIND_BEACON, 0, 0, CLS_OTHER);
		st(2'h0, 0);
		bus(1, OFS_CTRL, 32'h2);
		repeat (12) begin
			rd = $random(seed) & 32'h1ff;
			if (rd == 32'h100) rd = 32'h101;
			mac(KIND_CLAIM, 0, rd, (rd > 32'h100) ? CLS_HIGHER : CLS_LOWER);
			mac(KIND_BEACON, rd[0], rd, rd[0] ? CLS_MY : CLS_OTHER);
		end
		repeat (40) frame();
		end_sim();
	end
endmodule
bind rscb_ring rscb_ring_chk u_rscb_ring_chk (.hclk, .hresetn, .hreadyout, .hresp, .rx_sym_a, .rx_sym_b,
	.tx_sym_a, .tx_sym_b, .fcs_bad_in, .mac_frame_valid_in, .mac_frame_kind_in, .sa_match_in, .tx_ready_in,
	.imm_done_in, .gen_byte, .gen_valid, .imm_grant, .token_issue, .ring_operational, .rx_report_valid,
	.rx_report_kind, .rx_report_class);
